// *** rtl/msc_eng_if.sv ***
// signals between the register side and the send engine
`timescale 1ns/1ps
`default_nettype none
interface msc_eng_if;
    logic        start;
    logic [5:0]  size;
    logic [12:0] limit;
    logic        run;
    logic        tick;
    logic        ok;
    logic        nordy;
    logic        fail;
    logic        pkt_req;
    logic        busy;
    logic        done;
    logic [5:0]  err;
    logic [12:0] elapsed;

    modport eng (input start, size, limit, run, tick, ok, nordy, fail,
                 output pkt_req, busy, done, err, elapsed);
    modport ctl (output start, size, limit, run, tick, ok, nordy, fail,
                 input pkt_req, busy, done, err, elapsed);
endinterface : msc_eng_if
`default_nettype wire

// *** rtl/msc_pkg.sv ***
// constants, field layout and types for the mail send control block
package msc_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 16;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [11:0] OFS_SEND_CTRL   = 12'h000;
    localparam logic [11:0] OFS_SEND_LIMIT  = 12'h004;
    localparam logic [11:0] OFS_SEND_RESULT = 12'h008;
    localparam logic [11:0] OFS_ERR_STATUS  = 12'h00C;
    localparam logic [11:0] OFS_SYS_CTRL    = 12'h010;
    localparam logic [11:0] OFS_SYS_STATUS  = 12'h014;
    localparam logic [11:0] OFS_RX0_CTRL    = 12'h018;
    localparam logic [11:0] OFS_RX_STEP     = 12'h004;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h020;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h024;
    localparam logic [1:0]  BUF_WINDOW      = 2'h1;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned CTL_ERR_BIT   = 15;
    localparam int unsigned CTL_GO_BIT    = 14;
    localparam int unsigned CTL_DEST_LSB  = 8;
    localparam int unsigned CTL_SIZE_LSB  = 0;
    localparam int unsigned RUN_BIT       = 9;
    localparam int unsigned STS_ERR_BIT   = 7;
    localparam int unsigned STS_RX_BIT    = 6;
    localparam int unsigned RX_ARM_BIT    = 6;
    localparam int unsigned RX_DONE_BIT   = 7;
    localparam int unsigned RX_SRC_LSB    = 8;
    localparam int unsigned ERR_NORDY     = 0;
    localparam int unsigned ERR_ABSENT    = 1;
    localparam int unsigned ERR_TOUT      = 2;
    localparam int unsigned ERR_SZFLT     = 3;
    localparam int unsigned ERR_LMFLT     = 4;
    localparam int unsigned ERR_STOP      = 5;
    localparam int unsigned IRQ_TX_DONE   = 0;
    localparam int unsigned IRQ_RX0       = 1;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [12:0] LIMIT_RESET = 13'h1FFF;
    localparam logic [5:0]  SIZE_MAX    = 6'h20;
    localparam logic [1:0]  RETRY_MAX   = 2'h3;

    // send engine states, gray along idle, wait, send
    typedef enum logic [1:0] {
        ENG_IDLE = 2'h0,
        ENG_WAIT = 2'h1,
        ENG_SEND = 2'h3
    } msc_eng_st_t;

endpackage : msc_pkg

// *** rtl/msc_send_engine.sv ***
// mail send sequencer: packet per network cycle, retries, timeout
`timescale 1ns/1ps
`default_nettype none
module msc_send_engine #(
    parameter logic [1:0] RETRIES = msc_pkg::RETRY_MAX
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    msc_eng_if.eng    e_if
);
    import msc_pkg::*;

    typedef struct packed {
        msc_eng_st_t st;
        logic [1:0]  retry;
        logic [12:0] elapsed;
        logic [5:0]  err;
        logic        done;
        logic        pkt_req;
    } msc_eng_state_t;

    msc_eng_state_t r;
    msc_eng_state_t n;
    logic           fin;
    logic [5:0]     e;
    logic [12:0]    elap_inc;

    assign elap_inc = 13'(r.elapsed + 13'h0001);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin : eng_next
        n = r;
        n.done = 1'h0;
        n.pkt_req = 1'h0;
        fin = 1'h0;
        e = 6'h00;
        case (r.st)
            ENG_IDLE: begin
                if (e_if.start) begin
                    n.elapsed = 13'h0000;
                    n.retry = 2'h0;
                    if (!e_if.run) begin
                        e[ERR_STOP] = 1'h1;
                    end else if (e_if.size == 6'h00 || e_if.size > SIZE_MAX) begin
                        e[ERR_SZFLT] = 1'h1;
                    end else if (e_if.limit == 13'h0000) begin
                        e[ERR_LMFLT] = 1'h1;
                    end else begin
                        n.st = ENG_WAIT;
                    end
                end
            end
            ENG_WAIT, ENG_SEND: begin
                if (e_if.tick) begin
                    n.elapsed = elap_inc;
                end
                // a stopped network ends the transfer before anything else
                if (!e_if.run) begin
                    e[ERR_STOP] = 1'h1;
                end else if (r.st == ENG_SEND && e_if.ok) begin
                    fin = 1'h1;
                end else if (r.st == ENG_SEND && e_if.nordy) begin
                    e[ERR_NORDY] = 1'h1;
                end else if (r.st == ENG_SEND && e_if.fail) begin
                    if (r.retry == RETRIES) begin
                        e[ERR_ABSENT] = 1'h1;
                    end else begin
                        n.retry = 2'(r.retry + 2'h1);
                        n.st = ENG_WAIT;
                    end
                end else if (e_if.tick && elap_inc >= e_if.limit) begin
                    e[ERR_TOUT] = 1'h1;
                end else if (r.st == ENG_WAIT && e_if.tick) begin
                    n.pkt_req = 1'h1;
                    n.st = ENG_SEND;
                end
            end
            default: begin
                n.st = ENG_IDLE;
            end
        endcase
        if (fin || e != 6'h00) begin
            n.st = ENG_IDLE;
            n.done = 1'h1;
            n.err = e;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin : eng_reg
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign e_if.pkt_req = r.pkt_req;
    assign e_if.busy    = (r.st != ENG_IDLE);
    assign e_if.done    = r.done;
    assign e_if.err     = r.err;
    assign e_if.elapsed = r.elapsed;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_RETRY_ABSENT: assert property (
        (r.st == ENG_SEND && e_if.run && !e_if.ok && !e_if.nordy && e_if.fail
         && r.retry == RETRIES) |=> (r.done && r.err[ERR_ABSENT] && r.st == ENG_IDLE))
        else $error("final failed retry did not end with absent error");
    AST_SIZE_FAULT: assert property (
        (r.st == ENG_IDLE && e_if.start && e_if.run && e_if.size > SIZE_MAX)
        |=> (r.done && r.err[ERR_SZFLT]))
        else $error("oversize dataset not refused");
    CV_ABSENT: cover property (r.done && r.err[ERR_ABSENT]);
endmodule : msc_send_engine
`default_nettype wire

// *** rtl/msc_top.sv ***
// mail send control: registers, send buffer, receive control and irq
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module msc_top #(
    parameter int unsigned BUF_BYTES = 256
) (
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    input  wire logic [msc_pkg::AW-1:0]   reg_addr,
    input  wire logic [msc_pkg::DW-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [msc_pkg::DW-1:0]   reg_rdata,
    output logic                          irq,
    input  wire logic                     net_cycle_tick,
    output logic                          tx_pkt_req,
    output logic      [5:0]               tx_dest_station,
    output logic      [5:0]               tx_size_units,
    input  wire logic [7:0]               tx_buf_addr,
    output logic      [7:0]               tx_buf_data,
    input  wire logic                     tx_ok,
    input  wire logic                     tx_not_ready,
    input  wire logic                     tx_fail,
    input  wire logic                     rx_store,
    input  wire logic [5:0]               rx_size,
    input  wire logic [5:0]               rx_src
);
    import msc_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (BUF_BYTES != 256) begin : g_bad_buf
        $error("send buffer must be 256 bytes for the 8-bit window");
    end

    typedef struct packed {
        logic [5:0]       ctl_size;
        logic [5:0]       ctl_dest;
        logic             ctl_go;
        logic [12:0]      limit;
        logic [12:0]      result;
        logic [5:0]       err_sts;
        logic             run;
        logic [1:0][13:0] rx;
        logic [2:0]       irq_sts;
        logic [2:0]       irq_mask;
        logic             irq;
        logic [15:0]      rdata;
        logic [7:0]       txd;
    } msc_state_t;

    msc_state_t r;
    msc_state_t n;
    logic       start;
    logic       buf_we;
    logic       sel0;
    logic       sel1;
    logic [7:0] mem [BUF_BYTES];

    msc_eng_if eng ();

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] o);
        return a == o;
    endfunction : hit

    function automatic logic buf_hit(input logic [AW-1:0] a);
        return a[11:10] == BUF_WINDOW;
    endfunction : buf_hit

    // ****************************************
    // next state
    // ****************************************
    always_comb begin : top_next
        n = r;
        start = 1'h0;
        buf_we = 1'h0;
        sel0 = 1'h0;
        sel1 = 1'h0;
        n.rdata = 16'h0000;
        n.txd = mem[tx_buf_addr];
        // software writes; send control fields frozen while a transfer runs
        if (reg_wr) begin
            if (hit(reg_addr, OFS_SEND_CTRL) && !r.ctl_go) begin
                n.ctl_size = reg_wdata[CTL_SIZE_LSB +: 6];
                n.ctl_dest = reg_wdata[CTL_DEST_LSB +: 6];
                if (reg_wdata[CTL_GO_BIT] && r.err_sts == 6'h00) begin
                    n.ctl_go = 1'h1;
                    start = 1'h1;
                end
            end
            if (hit(reg_addr, OFS_SEND_LIMIT)) begin
                n.limit = reg_wdata[12:0];
            end
            if (hit(reg_addr, OFS_ERR_STATUS)) begin
                n.err_sts = 6'h00;
            end
            if (hit(reg_addr, OFS_SYS_CTRL)) begin
                n.run = reg_wdata[RUN_BIT];
            end
            for (int i = 0; i < 2; i++) begin
                if (hit(reg_addr, 12'(OFS_RX0_CTRL + OFS_RX_STEP * i))) begin
                    if (r.run) begin
                        n.rx[i][RX_ARM_BIT] = reg_wdata[RX_ARM_BIT];
                    end
                    if (!reg_wdata[RX_DONE_BIT]) begin
                        n.rx[i][RX_DONE_BIT] = 1'h0;
                    end
                end
            end
            if (hit(reg_addr, OFS_IRQ_STATUS)) begin
                n.irq_sts = r.irq_sts & ~reg_wdata[2:0];
            end
            if (hit(reg_addr, OFS_IRQ_MASK)) begin
                n.irq_mask = reg_wdata[2:0];
            end
            // buffer is write-protected while go stands
            buf_we = buf_hit(reg_addr) && !r.ctl_go;
        end
        // completion: hardware sets win over a same-cycle clear
        if (eng.done) begin
            n.ctl_go = 1'h0;
            n.result = eng.elapsed;
            n.err_sts = n.err_sts | eng.err;
            n.irq_sts[IRQ_TX_DONE] = 1'h1;
        end
        // incoming mail lands in buffer 0 first when both are armed
        if (rx_store && r.run) begin
            sel0 = r.rx[0][RX_ARM_BIT];
            sel1 = !sel0 && r.rx[1][RX_ARM_BIT];
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? sel0 : sel1) begin
                    n.rx[i] = {rx_src, 2'h2, rx_size};
                    n.irq_sts[IRQ_RX0 + i] = 1'h1;
                end
            end
        end
        // network stop drops every receive claim
        if (r.run && !n.run) begin
            for (int i = 0; i < 2; i++) begin
                n.rx[i][RX_ARM_BIT] = 1'h0;
                n.rx[i][RX_DONE_BIT] = 1'h0;
            end
        end
        // reads answer one cycle later
        if (reg_rd) begin
            if (hit(reg_addr, OFS_SEND_CTRL)) begin
                n.rdata = {r.err_sts != 6'h00, r.ctl_go, r.ctl_dest, 2'h0, r.ctl_size};
            end else if (hit(reg_addr, OFS_SEND_LIMIT)) begin
                n.rdata = {3'h0, r.limit};
            end else if (hit(reg_addr, OFS_SEND_RESULT)) begin
                n.rdata = {3'h0, r.result};
            end else if (hit(reg_addr, OFS_ERR_STATUS)) begin
                n.rdata = {10'h000, r.err_sts};
            end else if (hit(reg_addr, OFS_SYS_CTRL)) begin
                n.rdata = {6'h00, r.run, 9'h000};
            end else if (hit(reg_addr, OFS_SYS_STATUS)) begin
                n.rdata[STS_ERR_BIT] = r.err_sts != 6'h00;
                n.rdata[STS_RX_BIT] = r.rx[0][RX_DONE_BIT] | r.rx[1][RX_DONE_BIT];
            end else if (hit(reg_addr, OFS_RX0_CTRL)) begin
                n.rdata = {2'h0, r.rx[0]};
            end else if (hit(reg_addr, 12'(OFS_RX0_CTRL + OFS_RX_STEP))) begin
                n.rdata = {2'h0, r.rx[1]};
            end else if (hit(reg_addr, OFS_IRQ_STATUS)) begin
                n.rdata = {13'h0000, r.irq_sts};
            end else if (hit(reg_addr, OFS_IRQ_MASK)) begin
                n.rdata = {13'h0000, r.irq_mask};
            end else if (buf_hit(reg_addr) && !r.ctl_go) begin
                n.rdata = {8'h00, mem[reg_addr[9:2]]};
            end
        end
        n.irq = (n.irq_sts & n.irq_mask) != 3'h0;
    end

    // state register; limit comes out of reset at its all-ones maximum
    always_ff @(posedge core_clk or negedge arst_n) begin : top_reg
        if (!arst_n) begin
            r <= '0;
            r.limit <= LIMIT_RESET;
        end else begin
            r <= n;
        end
    end

    // send buffer storage, no reset: contents undefined until filled
    always_ff @(posedge core_clk) begin : buf_mem
        if (buf_we) begin
            mem[reg_addr[9:2]] <= reg_wdata[7:0];
        end
    end

    // ****************************************
    // engine hookup
    // ****************************************
    assign eng.start = start;
    assign eng.size  = n.ctl_size;
    assign eng.limit = r.limit;
    assign eng.run   = r.run;
    assign eng.tick  = net_cycle_tick;
    assign eng.ok    = tx_ok;
    assign eng.nordy = tx_not_ready;
    assign eng.fail  = tx_fail;

    msc_send_engine u_eng (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .e_if     (eng)
    );

    assign reg_rdata       = r.rdata;
    assign irq             = r.irq;
    assign tx_pkt_req      = eng.pkt_req;
    assign tx_dest_station = r.ctl_dest;
    assign tx_size_units   = r.ctl_size;
    assign tx_buf_data     = r.txd;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_ERR_BLOCKS_GO: assert property (
        (reg_wr && hit(reg_addr, OFS_SEND_CTRL) && reg_wdata[CTL_GO_BIT]
         && r.err_sts != 6'h00 && !r.ctl_go) |=> !r.ctl_go)
        else $error("go accepted while error flag set");
    AST_GO_STARTS: assert property (
        start |=> (r.ctl_go && (eng.busy || eng.done)))
        else $error("go write did not start the engine");
    AST_GO_CLEARS: assert property (
        eng.done |=> (!r.ctl_go ##1 (!r.ctl_go || $past(start))))
        else $error("go not cleared at completion");
    AST_BUF_READ_ZERO: assert property (
        (reg_rd && buf_hit(reg_addr) && r.ctl_go) |=> reg_rdata == 16'h0000)
        else $error("buffer read nonzero during transfer");
    AST_BUF_WRITE_BLOCK: assert property (
        (r.ctl_go && reg_wr && buf_hit(reg_addr))
        |=> mem[$past(reg_addr[9:2])] == $past(mem[reg_addr[9:2]]))
        else $error("buffer written during transfer");
    AST_RESULT_LATCH: assert property (
        eng.done |=> r.result == $past(eng.elapsed))
        else $error("elapsed count not latched");
    AST_RESULT_HOLD: assert property (
        !eng.done |=> $stable(r.result))
        else $error("result changed without completion");
    AST_ERR_SET: assert property (
        (eng.done && eng.err != 6'h00) |=> (r.err_sts != 6'h00 && !r.ctl_go))
        else $error("failed transfer left error flag clear");
    AST_ERRSTS_CLEAR: assert property (
        (reg_wr && hit(reg_addr, OFS_ERR_STATUS) && !eng.done) |=> r.err_sts == 6'h00)
        else $error("error status write did not clear");
    AST_RUN_FALL: assert property (
        $fell(r.run) |-> (r.rx[0][7:6] == 2'h0 && r.rx[1][7:6] == 2'h0))
        else $error("receive bits survive network stop");
    AST_ARM_NEEDS_RUN: assert property (
        (!r.run && !$past(r.run) && reg_wr && hit(reg_addr, OFS_RX0_CTRL))
        |=> !r.rx[0][RX_ARM_BIT])
        else $error("receive armed while network stopped");
    AST_LIMIT_HOLD: assert property (
        !(reg_wr && hit(reg_addr, OFS_SEND_LIMIT)) |=> $stable(r.limit))
        else $error("limit changed without a write");
    AST_IRQ_DONE: assert property (
        (eng.done && r.irq_mask[IRQ_TX_DONE]
         && !(reg_wr && hit(reg_addr, OFS_IRQ_MASK))) |=> irq)
        else $error("enabled completion raised no interrupt");

    CV_OK_SEND: cover property (eng.done && eng.err == 6'h00);
    CV_RX_STORE: cover property (rx_store && r.run && r.rx[0][RX_ARM_BIT]);
    CV_ERR_CLEAR: cover property (r.err_sts != 6'h00 ##1 r.err_sts == 6'h00);
endmodule : msc_top
`default_nettype wire

// *** sim/mail_send_control_tb.sv ***
// self-checking bench for the mail send control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mail_send_control_tb;
    import msc_pkg::*;
    typedef struct {logic [11:0] a; logic [15:0] w; logic [15:0] e;} msc_row_t;
    logic core_clk, arst_n, reg_wr, reg_rd, irq, tick, pkt, ok, nrdy, fail, rx_store;
    logic [11:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [5:0]  dest, size, rx_size, rx_src;
    logic [7:0]  baddr, bdata;
    logic [1:0]  mode;
    int          errors, compares;
    int          pkts = 0;
    msc_row_t    rows[6];
    msc_top DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .net_cycle_tick(tick), .tx_pkt_req(pkt), .tx_dest_station(dest),
        .tx_size_units(size), .tx_buf_addr(baddr), .tx_buf_data(bdata), .tx_ok(ok),
        .tx_not_ready(nrdy), .tx_fail(fail), .rx_store(rx_store), .rx_size(rx_size),
        .rx_src(rx_src));
    msc_link_model LINK (.core_clk(core_clk), .arst_n(arst_n), .mode(mode),
        .tx_pkt_req(pkt), .net_cycle_tick(tick), .tx_ok(ok), .tx_not_ready(nrdy),
        .tx_fail(fail), .tx_buf_addr(baddr));
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic wr(input logic [11:0] a, input logic [15:0] w);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // step past the edge so later checks see the write's effect, not the old state
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [11:0] a, output logic [15:0] q);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd
    // poll go with a bound so a stuck engine cannot hang the run
    task automatic wait_idle;
        int n;
        n = 0;
        d = 16'h4000;
        while (d[CTL_GO_BIT] === 1'b1 && n < 300) begin
            rd(OFS_SEND_CTRL, d);
            n++;
        end
    endtask : wait_idle
    task automatic final_report;
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // ****************************************
    // clock, watchdog, sequence
    // ****************************************
    always #50 core_clk = ~core_clk;
    // count packet requests put on the link
    always @(posedge core_clk) begin
        if (pkt === 1'b1) begin
            pkts++;
        end
    end
    initial begin
        #2000000;
        errors++;
        final_report();
    end
    initial begin
        core_clk = 0; arst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        mode = 0; rx_store = 0; rx_size = 0; rx_src = 0; errors = 0; compares = 0;
        rows = '{'{OFS_SEND_LIMIT, 16'h0123, 16'h0123}, '{OFS_IRQ_MASK, 16'h0001, 16'h0001},
                 '{OFS_SYS_CTRL, 16'h0200, 16'h0200}, '{12'h400, 16'h00AB, 16'h00AB},
                 '{OFS_SEND_RESULT, 16'hFFFF, 16'h0000}, '{12'h3F0, 16'hFFFF, 16'h0000}};
        repeat (8) @(posedge core_clk);
        `CHK("irq_rst", 1'b0, irq)
        arst_n <= 1'b1;
        rd(OFS_SEND_LIMIT, d);
        `CHK("limit_rst", 16'h1FFF, d)
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            `CHK("row", rows[i].e, d)
        end
        `CHK("link_byte", 8'hAB, bdata)
        // good transfer: buffer locked while busy, then result and irq
        wr(OFS_SEND_CTRL, 16'h4205);
        rd(12'h400, d);
        `CHK("buf_locked_rd", 16'h0000, d)
        wr(12'h400, 16'h0055);
        rd(OFS_SEND_CTRL, d);
        `CHK("go_set", 1'b1, d[CTL_GO_BIT])
        `CHK("dest", 6'h02, dest)
        `CHK("size", 6'h05, size)
        wait_idle();
        `CHK("ctrl_done", 16'h0205, d)
        `CHK("pkt_count", 1, pkts)
        rd(OFS_SEND_RESULT, d);
        `CHK("elapsed", 16'h0001, d)
        `CHK("irq_done", 1'b1, irq)
        rd(12'h400, d);
        `CHK("buf_kept", 16'h00AB, d)
        rd(OFS_SEND_LIMIT, d);
        `CHK("limit_kept", 16'h0123, d)
        wr(OFS_IRQ_STATUS, 16'h0001);
        `CHK("irq_clr", 1'b0, irq)
        // failing transfers: retries exhausted, then destination not armed
        for (int i = 0; i < 2; i++) begin
            mode <= i ? 2'h2 : 2'h1;
            wr(OFS_SEND_CTRL, 16'h4205);
            wait_idle();
            `CHK("err_flag", 1'b1, d[CTL_ERR_BIT])
            `CHK("pkt_retry", i ? 6 : 5, pkts)
            rd(OFS_ERR_STATUS, d);
            `CHK("err_kind", i ? 16'h0001 : 16'h0002, d)
            rd(OFS_SEND_RESULT, d);
            `CHK("elapsed_err", i ? 16'h0001 : 16'h0004, d)
            rd(OFS_SYS_STATUS, d);
            `CHK("sys_err", 1'b1, d[STS_ERR_BIT])
            wr(OFS_SEND_CTRL, 16'h4205);
            rd(OFS_SEND_CTRL, d);
            `CHK("go_refused", 1'b0, d[CTL_GO_BIT])
            wr(OFS_ERR_STATUS, 16'h0000);
            rd(OFS_SEND_CTRL, d);
            `CHK("err_cleared", 1'b0, d[CTL_ERR_BIT])
        end
        // refused starts and early timeout: oversize dataset, zero limit, limit reached at the first tick
        for (int i = 0; i < 3; i++) begin
            wr(OFS_SEND_LIMIT, (i == 1) ? 16'h0000 : ((i == 2) ? 16'h0001 : 16'h0123));
            wr(OFS_SEND_CTRL, (i == 0) ? 16'h4221 : 16'h4205);
            wait_idle();
            rd(OFS_ERR_STATUS, d);
            `CHK("err_start", (i == 0) ? 16'h0008 : ((i == 1) ? 16'h0010 : 16'h0004), d)
            wr(OFS_ERR_STATUS, 16'h0000);
        end
        // receive control: store, then run falls, then arming while stopped
        wr(OFS_RX0_CTRL, 16'h0040);
        @(posedge core_clk);
        rx_store <= 1'b1;
        rx_size  <= 6'h05;
        rx_src   <= 6'h03;
        @(posedge core_clk);
        rx_store <= 1'b0;
        rd(OFS_RX0_CTRL, d);
        `CHK("rx0_store", 16'h0385, d)
        rd(OFS_RX0_CTRL, d);
        `CHK("rx0_reread", 16'h0385, d)
        rd(OFS_SYS_STATUS, d);
        `CHK("rx_summary", 1'b1, d[STS_RX_BIT])
        wr(OFS_SYS_CTRL, 16'h0000);
        rd(OFS_RX0_CTRL, d);
        `CHK("rx0_stop", 16'h0000, d & 16'h00C0)
        wr(OFS_RX0_CTRL, 16'h0040);
        rd(OFS_RX0_CTRL, d);
        `CHK("rx0_arm_off", 1'b0, d[RX_ARM_BIT])
        final_report();
    end
endmodule : mail_send_control_tb
`default_nettype wire

// *** sim/msc_link_model.sv ***
// far side of the link: cycle ticks and packet answers
`timescale 1ns/1ps
`default_nettype none
module msc_link_model (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] mode,
    input  wire logic       tx_pkt_req,
    output logic            net_cycle_tick,
    output logic            tx_ok,
    output logic            tx_not_ready,
    output logic            tx_fail,
    output logic [7:0]      tx_buf_addr
);
    logic [5:0] div_reg;
    logic [2:0] dly_reg;
    // link peeks at buffer byte 0 only
    assign tx_buf_addr = 8'h00;
    // tick every 40 clocks; answer 3 clocks after a packet, well before the next tick
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 6'h00;
            dly_reg <= 3'h0;
        end else begin
            div_reg <= (div_reg == 6'h27) ? 6'h00 : div_reg + 6'h01;
            dly_reg <= {dly_reg[1:0], tx_pkt_req};
        end
    end
    assign net_cycle_tick = (div_reg == 6'h27);
    assign tx_ok          = dly_reg[2] && (mode == 2'h0);
    assign tx_fail        = dly_reg[2] && (mode == 2'h1);
    assign tx_not_ready   = dly_reg[2] && (mode == 2'h2);
endmodule : msc_link_model
`default_nettype wire
